/* common/crce_pkg.sv */
// Shared constants and types for the checksum engine.
// Assumes a 32-bit AXI4-Lite register bus and a single system clock.
package crce_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [3:0] OFF_MODE = 4'h0;
  localparam logic [3:0] OFF_SUM  = 4'h4;   // Write loads seed, read gives sum
  localparam logic [3:0] OFF_DATA = 4'h8;   // Write-only data port
  localparam logic [3:0] OFF_STAT = 4'hc;

  // ==========================================================
  // Mode register fields
  localparam int MODE_POLY_LO = 0;
  localparam int MODE_POLY_HI = 1;
  localparam int MODE_IN_RVS  = 2;
  localparam int MODE_IN_CMP  = 3;
  localparam int MODE_OUT_RVS = 4;
  localparam int MODE_OUT_CMP = 5;
  localparam int MODE_W       = 6;
  localparam logic [MODE_W-1:0] MODE_RST = 6'h00;

  // Status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_FULL = 1;

  // ==========================================================
  // Polynomial selection codes and generator values
  localparam logic [1:0]  POLY_CCITT   = 2'h0;
  localparam logic [1:0]  POLY_CRC16   = 2'h1;
  localparam logic [1:0]  POLY_CRC32   = 2'h2;
  localparam logic [15:0] GEN_CCITT    = 16'h1021;
  localparam logic [15:0] GEN_CRC16    = 16'h8005;
  localparam logic [31:0] GEN_CRC32    = 32'h04c11db7;
  localparam logic [31:0] ACC_RST      = 32'h00000000;

  // ==========================================================
  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // One queued data write: the word and the byte lanes it carries
  typedef struct packed {
    logic [31:0] data;
    logic [3:0]  strb;
  } crce_entry_s;

endpackage

/* logic/crce_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides and a flush.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module crce_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 4
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // ==========================================================
  // Elaboration checks
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("DEPTH must be a power of two >= 2");
    if (WIDTH < 1) $error("WIDTH must be positive");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wp_r;
  logic [PW-1:0]    rp_r;
  logic [PW:0]      cnt_r;
  logic             push;
  logic             pop;

  // Handshakes; full and empty come straight from the count
  assign in_ready  = (cnt_r != (PW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid && in_ready && !flush;
  assign pop       = out_valid && out_ready && !flush;

  // Storage array, no reset needed on data
  always_ff @(posedge aclk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge aclk) begin
    if (!aresetn || flush) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule

/* logic/crce_top.sv */
// Checksum engine with AXI4-Lite register access and a queued data port.
// Assumes a single 40 MHz clock, synchronous active-low reset, one master.
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
module crce_top
  import crce_pkg::*;
#(
  parameter int ADDR_W     = 4,
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // ==========================================================
  // Elaboration checks
  initial begin
    if (ADDR_W < 4) $error("ADDR_W must be at least 4");
    if (FIFO_DEPTH < 2) $error("FIFO_DEPTH must be at least 2");
  end

  // ==========================================================
  // Helper functions
  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) r[i] = v[7-i];
    return r;
  endfunction

  function automatic logic [31:0] rev32(input logic [31:0] v);
    logic [31:0] r;
    for (int i = 0; i < 32; i++) r[i] = v[31-i];
    return r;
  endfunction

  // One byte step, most significant bit of the byte first
  function automatic logic [31:0] crc_byte(input logic [31:0] acc, input logic [7:0] b,
                                           input logic [1:0] sel);
    logic [31:0] c;
    logic        fb;
    c = acc;
    for (int i = 7; i >= 0; i--) begin
      if (sel == POLY_CRC32) begin
        fb = c[31] ^ b[i];
        c  = {c[30:0], 1'b0};
        if (fb) c = c ^ GEN_CRC32;
      end else begin
        fb = c[15] ^ b[i];
        c  = {16'h0000, c[14:0], 1'b0};
        if (fb) c = c ^ {16'h0000, (sel == POLY_CRC16) ? GEN_CRC16 : GEN_CCITT};
      end
    end
    return c;
  endfunction

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // ==========================================================
  // State
  logic [MODE_W-1:0] mode_r;
  logic [31:0]       acc_r;
  logic [31:0]       cur_data_r;
  logic [3:0]        cur_mask_r;
  logic              aw_hold_r;
  logic              w_hold_r;
  logic [ADDR_W-1:0] waddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;

  logic        wr_commit;
  logic        wr_data;
  logic        seed_wr;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_out_ready;
  crce_entry_s fifo_out;
  crce_entry_s fifo_in;
  logic        ld;
  logic        step;
  logic [3:0]  low_oh;
  logic [3:0]  mask_after;
  logic [7:0]  raw_byte;
  logic [7:0]  byte_in;
  logic [31:0] acc_step;
  logic [31:0] sum_out;
  logic [31:0] seed_mask;
  logic [31:0] acc_rev;
  logic        is32;
  logic        busy;

  // ==========================================================
  // AXI4-Lite write channel
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready  = !w_hold_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  // Data writes wait here while the queue is full, which stalls the feeder
  assign wr_data   = (waddr_r == ADDR_W'(OFF_DATA));
  assign wr_commit = aw_hold_r && w_hold_r && !bvalid_r && (!wr_data || fifo_in_ready);
  assign seed_wr   = wr_commit && (waddr_r == ADDR_W'(OFF_SUM));

  // Address and data are caught independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      waddr_r   <= '0;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        waddr_r   <= s_axi_awaddr;
      end else if (wr_commit) begin
        aw_hold_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (wr_commit) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  // Write response, error for unmapped or read-only offsets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_commit) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (waddr_r == ADDR_W'(OFF_MODE) || waddr_r == ADDR_W'(OFF_SUM) || wr_data)
                  ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Mode register, byte lane 0 only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= MODE_RST;
    end else if (wr_commit && waddr_r == ADDR_W'(OFF_MODE) && wstrb_r[0]) begin
      mode_r <= wdata_r[MODE_W-1:0];
    end
  end

  // ==========================================================
  // Data queue: decouples bus writes from the byte engine
  assign fifo_in.data = wdata_r;
  assign fifo_in.strb = wstrb_r;

  crce_fifo #(
    .WIDTH ($bits(crce_entry_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .flush     (seed_wr),
    .in_valid  (wr_commit && wr_data && (wstrb_r != 4'h0)),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out)
  );

  // ==========================================================
  // Byte engine: lowest remaining lane first, one lane per cycle
  assign step       = (cur_mask_r != 4'h0);
  assign low_oh     = cur_mask_r & (~cur_mask_r + 4'h1);
  assign mask_after = cur_mask_r & ~low_oh;
  assign fifo_out_ready = (mask_after == 4'h0) && !seed_wr;
  assign ld         = fifo_out_valid && fifo_out_ready;
  assign is32       = (mode_r[MODE_POLY_HI:MODE_POLY_LO] == POLY_CRC32);
  assign busy       = step || fifo_out_valid;

  // Input byte selection and conditioning
  always_comb begin
    raw_byte = 8'h00;
    for (int i = 0; i < 4; i++) begin
      if (low_oh[i]) raw_byte = cur_data_r[8*i +: 8];
    end
    byte_in = mode_r[MODE_IN_RVS] ? rev8(raw_byte) : raw_byte;
    byte_in = mode_r[MODE_IN_CMP] ? ~byte_in : byte_in;
    acc_step = crc_byte(acc_r, byte_in, mode_r[MODE_POLY_HI:MODE_POLY_LO]);
  end

  // Current word: reload the next entry as the last byte goes in
  always_ff @(posedge aclk) begin
    if (!aresetn || seed_wr) begin
      cur_mask_r <= 4'h0;
      cur_data_r <= 32'h00000000;
    end else if (ld) begin
      cur_mask_r <= fifo_out.strb;
      cur_data_r <= fifo_out.data;
    end else begin
      cur_mask_r <= mask_after;
    end
  end

  // Seed lanes and mirrored sum as nets, so their halves can be sliced
  assign seed_mask = strb_mask(wstrb_r);
  assign acc_rev   = rev32(acc_r);

  // Accumulator: seed wins over a byte step in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_r <= ACC_RST;
    end else if (seed_wr) begin
      acc_r <= is32 ? (wdata_r & seed_mask)
                    : {16'h0000, wdata_r[15:0] & seed_mask[15:0]};
    end else if (step) begin
      acc_r <= acc_step;
    end
  end

  // Presented sum, reversal and inversion kept inside the active width
  always_comb begin
    if (is32) begin
      sum_out = mode_r[MODE_OUT_RVS] ? rev32(acc_r) : acc_r;
      sum_out = mode_r[MODE_OUT_CMP] ? ~sum_out : sum_out;
    end else begin
      sum_out = mode_r[MODE_OUT_RVS] ? {16'h0000, acc_rev[31:16]} : acc_r;
      sum_out = mode_r[MODE_OUT_CMP] ? {16'h0000, ~sum_out[15:0]} : sum_out;
    end
  end

  // ==========================================================
  // AXI4-Lite read channel; reads have no side effects
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rresp_r  <= RESP_OKAY;
      if (s_axi_araddr == ADDR_W'(OFF_MODE)) begin
        rdata_r <= {{(32-MODE_W){1'b0}}, mode_r};
      end else if (s_axi_araddr == ADDR_W'(OFF_SUM)) begin
        rdata_r <= sum_out;
      end else if (s_axi_araddr == ADDR_W'(OFF_STAT)) begin
        rdata_r <= 32'h00000000;
        rdata_r[STAT_BUSY] <= busy;
        rdata_r[STAT_FULL] <= !fifo_in_ready;
      end else if (s_axi_araddr == ADDR_W'(OFF_DATA)) begin
        rdata_r <= 32'h00000000;
      end else begin
        rdata_r <= 32'h00000000;
        rresp_r <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ==========================================================
  // Assertions
  AST_SEED_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
    seed_wr && is32 && wstrb_r == 4'hf |=> acc_r == $past(wdata_r) && cur_mask_r == 4'h0)
    else $error("seed write did not reload the accumulator");

  AST_BYTE_ONE: assert property (@(posedge aclk) disable iff (!aresetn)
    $countones(cur_mask_r) == 1 && !seed_wr && !ld |=> cur_mask_r == 4'h0)
    else $error("single byte not finished in one cycle");

  AST_HALF_TWO: assert property (@(posedge aclk) disable iff (!aresetn)
    cur_mask_r == 4'h3 && !seed_wr ##1 !seed_wr && !ld |=> cur_mask_r == 4'h0)
    else $error("halfword not finished in two cycles");

  AST_WORD_ORDER: assert property (@(posedge aclk) disable iff (!aresetn)
    cur_mask_r == 4'hf && !seed_wr |=> cur_mask_r == 4'he ##1 cur_mask_r == 4'hc || seed_wr
      || $past(seed_wr))
    else $error("word bytes not taken lowest first");

  AST_IDLE_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    !step && !seed_wr |=> $stable(acc_r))
    else $error("accumulator changed with no byte step");

  AST_NARROW_TOP: assert property (@(posedge aclk) disable iff (!aresetn)
    step && !seed_wr && !is32 |=> acc_r[31:16] == 16'h0000)
    else $error("16-bit remainder spilled into upper half");

  AST_READ_SUM: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_W'(OFF_SUM) && is32
      && mode_r[MODE_OUT_CMP] && !mode_r[MODE_OUT_RVS] |=> s_axi_rdata == ~$past(acc_r))
    else $error("sum read not inverted as selected");

  AST_FULL_STALL: assert property (@(posedge aclk) disable iff (!aresetn)
    aw_hold_r && w_hold_r && wr_data && !fifo_in_ready && !bvalid_r |=> !bvalid_r)
    else $error("data write answered while queue full");

endmodule

/* dv/crce_feeder.sv */
// Bus master standing in for the processor or DMA feeding the checksum engine.
// Assumes the engine's AXI4-Lite slave port and one clock; driven by bench tasks.
`timescale 1ns/100ps
module crce_feeder
  import crce_pkg::*;
(
  input  wire logic        aclk,
  output logic [3:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [3:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  // ==========================================================
  // Idle bus at time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // ==========================================================
  // One write; cycles counted so a stalled queue shows up as a long wait
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] resp, output int cyc);
    logic aw_p, w_p, done;
    aw_p = 1'b1;
    w_p  = 1'b1;
    done = 1'b0;
    cyc  = 0;
    // Starts on the caller's edge; bready stays high so calls can follow back to back
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // Consecutive writes need no pause between them
    while (!done) begin
      @(posedge aclk);
      cyc++;
      if (!aw_p && !w_p && bvalid) begin
        resp   = bresp;
        done   = 1'b1;
      end
      // Released lines flip so stale values cannot pass
      if (aw_p && awready) begin
        aw_p    = 1'b0;
        awvalid <= 1'b0;
        awaddr  <= ~a;
      end
      if (w_p && wready) begin
        w_p    = 1'b0;
        wvalid <= 1'b0;
        wdata  <= ~d;
        wstrb  <= ~s;
      end
    end
  endtask

  // One read
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ar_p, done;
    ar_p = 1'b1;
    done = 1'b0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (!ar_p && rvalid) begin
        d      = rdata;
        resp   = rresp;
        done   = 1'b1;
      end
      if (ar_p && arready) begin
        ar_p    = 1'b0;
        arvalid <= 1'b0;
        araddr  <= ~a;
      end
    end
  endtask
endmodule

/* dv/crc_engine_bench.sv */
// Self-checking bench for the checksum engine over its register bus.
// Assumes crce_top with default parameters and the crce_feeder bus master.
`timescale 1ns/100ps
module crc_engine_bench
  import crce_pkg::*;
;
  logic        aclk, aresetn;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          miscompares, checks, last_cyc;
  logic [1:0]  last_resp;

  // ==========================================================
  // Clock, design and bus master
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  crce_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  crce_feeder u_feed (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // ==========================================================
  // Reference sum: bytes lowest lane first, MSB first, non-reflected
  function automatic logic [31:0] ref_sum(logic [5:0] m, logic [31:0] seed,
                                          logic [31:0] d, logic [3:0] s);
    logic [31:0] acc, gen, msk, r;
    logic [7:0]  b;
    logic        fb;
    int          w;
    w   = (m[1:0] == POLY_CRC32) ? 32 : 16;
    gen = (m[1:0] == POLY_CRC32) ? GEN_CRC32 :
          (m[1:0] == POLY_CRC16) ? {16'h0000, GEN_CRC16} : {16'h0000, GEN_CCITT};
    msk = (w == 32) ? 32'hffffffff : 32'h0000ffff;
    acc = seed & msk;
    for (int i = 0; i < 4; i++) begin
      b = d[8*i +: 8];
      if (m[MODE_IN_RVS]) b = {<<{b}};
      if (m[MODE_IN_CMP]) b = ~b;
      for (int j = 7; j >= 0; j--) begin
        fb = acc[w-1] ^ b[j];
        if (s[i]) acc = ((acc << 1) & msk) ^ (fb ? gen : 32'h00000000);
      end
    end
    r = acc;
    if (m[MODE_OUT_RVS]) for (int k = 0; k < w; k++) r[k] = acc[w-1-k];
    if (m[MODE_OUT_CMP]) r = ~r & msk;
    return r;
  endfunction

  // ==========================================================
  // Shared compare and bus helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wreg(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    u_feed.wr(a, d, s, last_resp, last_cyc);
  endtask

  task automatic rreg(input logic [3:0] a, output logic [31:0] d);
    u_feed.rd(a, d, last_resp);
  endtask

  // Wait for idle engine, bounded
  task automatic wait_idle();
    logic [31:0] st;
    st = 32'h1;
    for (int i = 0; i < 60 && st[STAT_BUSY] !== 1'b0; i++) rreg(OFF_STAT, st);
    chk({31'h0, st[STAT_BUSY]}, 32'h0);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [31:0] v;
    rreg(OFF_MODE, v); chk(v, {26'h0, MODE_RST});
    rreg(OFF_SUM, v);  chk(v, ACC_RST);
    rreg(OFF_STAT, v); chk(v, 32'h0);
    rreg(OFF_DATA, v); chk(v, 32'h0);
    rreg(4'h1, v);     chk({30'h0, last_resp}, {30'h0, RESP_SLVERR});
    wreg(OFF_STAT, 32'h3, 4'hf); chk({30'h0, last_resp}, {30'h0, RESP_SLVERR});
    wreg(OFF_MODE, 32'h3f, 4'hf); rreg(OFF_MODE, v); chk(v, 32'h3f);
  endtask

  // Every generator code and input/output transform on one full word
  task automatic t_modes();
    logic [5:0]  tbl [10] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h0e, 6'h12, 6'h22, 6'h14,
                              6'h29, 6'h3e};
    logic [31:0] v, exp;
    foreach (tbl[i]) begin
      wreg(OFF_MODE, {26'h0, tbl[i]}, 4'hf);
      wreg(OFF_SUM, 32'h89abcdef, 4'hf);
      wreg(OFF_DATA, 32'h34333231, 4'hf);
      exp = ref_sum(tbl[i], 32'h89abcdef, 32'h34333231, 4'hf);
      repeat (4) @(posedge aclk);
      rreg(OFF_SUM, v); chk(v, exp);
      rreg(OFF_SUM, v); chk(v, exp);
    end
  endtask

  // Write widths: only carried lanes, one cycle per byte
  task automatic t_widths();
    logic [3:0]  st [7] = '{4'h1, 4'h4, 4'hc, 4'h6, 4'h3, 4'hf, 4'h0};
    int          nb [7] = '{1, 1, 2, 2, 2, 4, 0};
    logic [31:0] v;
    wreg(OFF_MODE, {30'h0, POLY_CRC32}, 4'hf);
    foreach (st[i]) begin
      wreg(OFF_SUM, 32'hffffffff, 4'hf);
      wreg(OFF_DATA, 32'hc3a55a3c, st[i]);
      repeat (nb[i]) @(posedge aclk);
      rreg(OFF_SUM, v);
      chk(v, ref_sum({4'h0, POLY_CRC32}, 32'hffffffff, 32'hc3a55a3c, st[i]));
      rreg(OFF_STAT, v); chk(v & 32'h1, 32'h0);
    end
  endtask

  // Back-to-back words overrun the queue; writes stall, nothing is lost
  task automatic t_b2b();
    logic [31:0] v, exp;
    int          maxc;
    maxc = 0;
    exp  = 32'h0;
    wreg(OFF_MODE, {30'h0, POLY_CRC16}, 4'hf);
    wreg(OFF_SUM, 32'h0, 4'hf);
    // Writes arrive every 3 cycles, words drain every 4: the queue fills
    for (int i = 0; i < 20; i++) begin
      wreg(OFF_DATA, 32'h01020304 * (i + 1), 4'hf);
      exp  = ref_sum({4'h0, POLY_CRC16}, exp, 32'h01020304 * (i + 1), 4'hf);
      maxc = (last_cyc > maxc) ? last_cyc : maxc;
    end
    chk({31'h0, maxc > 3}, 32'h1);
    wait_idle();
    rreg(OFF_SUM, v); chk(v, exp);
  endtask

  // Seed write in mid-stream drops queued data at once
  task automatic t_seed_abort();
    logic [31:0] v;
    wreg(OFF_MODE, {30'h0, POLY_CCITT}, 4'hf);
    for (int i = 0; i < 3; i++) wreg(OFF_DATA, 32'hdeadbeef, 4'hf);
    wreg(OFF_SUM, 32'habcd1234, 4'hf);
    rreg(OFF_STAT, v); chk(v, 32'h0);
    rreg(OFF_SUM, v);  chk(v, 32'h00001234);
  endtask

  // ==========================================================
  // Verdict, watchdog and main sequence
  task automatic wrap_up();
    if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #(30000 * 25);
    miscompares++;
    wrap_up();
  end

  initial begin
    miscompares = 0;
    checks      = 0;
    aresetn     = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_modes();
    t_widths();
    t_b2b();
    t_seed_abort();
    wrap_up();
  end
endmodule
